// file: hdl/prot_pkg.sv
// constants, register map and field layout for the axis protection block
package prot_pkg;

  localparam int NUM_AXES = 8;
  localparam int POS_W = 32;
  localparam int THR_W = 15;
  localparam int ADDR_W = 12;
  localparam int NUM_GIN = 16;

  // following error limit range and value after reset, in quadrature counts
  localparam logic [14:0] THRESH_MIN = 15'h0001;
  localparam logic [14:0] THRESH_MAX = 15'h7FFF;
  localparam logic [14:0] THRESH_RESET = 15'h4000;

  // servo update interval
  localparam int CLK_PERIOD_NS = 8;
  localparam int SERVO_PERIOD_NS = 1000;
  localparam int SERVO_CYCLES = (SERVO_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;
  localparam logic [7:0] TICK_LAST = 8'(SERVO_CYCLES - 1);

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] OFF_FAULT_OFS = 12'h004;
  localparam logic [11:0] CMD_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] LIMITS_OFS = 12'h010;
  localparam logic [11:0] THRESH_BASE = 12'h020;
  localparam logic [11:0] DEV_BASE = 12'h040;

  // control fields
  localparam int CTRL_SEL_ABORT_BIT = 0;
  localparam int CTRL_LIM_INV_BIT = 1;

  // command fields, write-one pulses
  localparam int CMD_OFF_LSB = 0;
  localparam int CMD_HOLD_LSB = 8;
  localparam int CMD_ABORT_BIT = 16;
  localparam int CMD_RESTART_BIT = 17;

  // status fields
  localparam int STAT_AMP_LSB = 0;
  localparam int STAT_EXCESS_LSB = 8;
  localparam int STAT_OFF_LSB = 16;
  localparam int STAT_FAULT_BIT = 24;
  localparam int STAT_ABORT_BIT = 25;

  // general inputs reused as per-axis aborts, axis 0 first
  localparam int SEL_INPUT_MAP [0:7] = '{5, 6, 7, 8, 13, 14, 15, 16};

  // width of the synchronised pin bundle: abort, general inputs, limits
  localparam int PIN_W = 1 + NUM_GIN + 2 * NUM_AXES;

endpackage

// file: hdl/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // stage1 feeds stage2 only
  always_comb
  begin
    next_r.stage1 = d;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r.stage1 <= RESET_VAL;
      r.stage2 <= RESET_VAL;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign q = r.stage2;

endmodule

// file: hdl/motion_axis_protection.sv
// per-axis following error, abort and limit protection with apb registers
// Contract
// - amp enable drops on motor-off, excess error, or abort with off-on-fault
// - each axis has its own independently controlled amp enable
// - all amp enables low during reset and when watchdog fires
// - amp enable output is active high: low disables amplifier
// - shared fault output low while any axis exceeds its error limit
// - fault output low while reset input is held low
// - fault output low while internal failure resets the processor
// - general abort low halts commanded motion at once, no ramp; halt_now is set only at the next servo tick after sync
// - general abort disables amp on axes with off-on-fault enabled
// - general abort without off-on-fault stops and holds axis position
// - selective abort maps inputs 5-8 and 13-16 to axes A-H
// - selective abort acts like general abort on its single axis
// - active forward limit blocks forward motion, decelerates forward move
// - active reverse limit blocks reverse motion, decelerates reverse move
// - limit hit while moving toward it raises limit handler event
// - configuration bit inverts limit switch active polarity
// - per-axis error limit programmable 1 to 32767, reset 16384
// - error limit in counts; error is commanded minus encoder position
// - excess error signals routine, lamp on, amp low, off if off-on-fault
// - excess error handler event each time any axis limit is exceeded
// - current following error of each axis readable at any time
// - per-axis off-on-fault bit, one enables and zero disables
// - after off-on-fault shutdown only restart or hold-here re-enables
`timescale 1ns/100ps
module motion_axis_protection (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0][31:0] cmd_pos,
  input wire logic [7:0][31:0] enc_pos,
  input wire logic [7:0] moving_fwd,
  input wire logic [7:0] moving_rev,
  input wire logic watchdog_fire,
  input wire logic self_reset,
  input wire logic abort_n,
  input wire logic [16:1] general_in,
  input wire logic [7:0] fwd_limit_n,
  input wire logic [7:0] rev_limit_n,
  output logic [7:0] amp_drive_allow,
  output logic fault_n,
  output logic error_lamp,
  output logic [7:0] halt_now,
  output logic [7:0] hold_here,
  output logic [7:0] block_fwd,
  output logic [7:0] block_rev,
  output logic [7:0] decel_stop,
  output logic limit_handler_routine,
  output logic excess_deviation_routine
);

  typedef struct packed {
    logic [7:0] tick_cnt;
    logic sel_abort;
    logic lim_invert;
    logic [7:0] disable_on_fault_set;
    logic [7:0][14:0] excess_threshold;
    logic [7:0][31:0] deviation;
    logic [7:0] excess;
    logic [7:0] off_latch;
    logic abort_pend;
    logic [7:0] amp;
    logic fault_n;
    logic lamp;
    logic [7:0] halt;
    logic [7:0] hold;
    logic [7:0] blk_fwd;
    logic [7:0] blk_rev;
    logic [7:0] decel;
    logic [7:0] lim_hit;
    logic lim_evt;
    logic exc_evt;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_s;

  state_s r;
  state_s next_r;

  logic [prot_pkg::PIN_W-1:0] pins_raw;
  logic [prot_pkg::PIN_W-1:0] pins_s;
  logic abort_n_s;
  logic [16:1] gin_s;
  logic [7:0] fwd_n_s;
  logic [7:0] rev_n_s;

  assign pins_raw = {rev_limit_n, fwd_limit_n, general_in, abort_n};

  // pins idle high, so the reset value reads as nothing active
  pin_sync #(
    .W(prot_pkg::PIN_W),
    .RESET_VAL({prot_pkg::PIN_W{1'b1}})
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign abort_n_s = pins_s[0];
  assign gin_s = pins_s[16:1];
  assign fwd_n_s = pins_s[24:17];
  assign rev_n_s = pins_s[32:25];

  always_comb
  begin
    logic tick;
    logic setup;
    logic wr;
    logic hit;
    logic is_thr;
    logic is_dev;
    logic [2:0] idx;
    logic [7:0] cmd_off;
    logic [7:0] cmd_hold;
    logic cmd_abort;
    logic cmd_restart;
    logic gen_abort;
    logic ab;
    logic fa;
    logic ra;
    logic lh;
    logic exc;
    logic [31:0] dev;
    logic [31:0] mag;
    logic [7:0] set_off;
    logic [7:0] clr_off;
    logic [14:0] thr_w;

    tick = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    is_thr = 1'b0;
    is_dev = 1'b0;
    idx = 3'h0;
    cmd_off = 8'h00;
    cmd_hold = 8'h00;
    cmd_abort = 1'b0;
    cmd_restart = 1'b0;
    gen_abort = 1'b0;
    ab = 1'b0;
    fa = 1'b0;
    ra = 1'b0;
    lh = 1'b0;
    exc = 1'b0;
    dev = 32'h0000_0000;
    mag = 32'h0000_0000;
    set_off = 8'h00;
    clr_off = 8'h00;
    thr_w = prot_pkg::THRESH_MIN;

    next_r = r;
    next_r.lim_evt = 1'b0;
    next_r.exc_evt = 1'b0;
    next_r.ready = 1'b0;
    next_r.slverr = 1'b0;

    // servo tick divider
    tick = (r.tick_cnt == prot_pkg::TICK_LAST);
    next_r.tick_cnt = tick ? 8'h00 : r.tick_cnt + 8'h01;

    // apb decode; answer is prepared in the setup cycle so the access
    // phase always completes in its first cycle
    setup = psel && !penable;
    is_thr = (paddr[11:5] == prot_pkg::THRESH_BASE[11:5]) && (paddr[1:0] == 2'h0);
    is_dev = (paddr[11:5] == prot_pkg::DEV_BASE[11:5]) && (paddr[1:0] == 2'h0);
    idx = paddr[4:2];

    if (setup)
    begin
      next_r.ready = 1'b1;
      next_r.rdata = 32'h0000_0000;
      hit = 1'b1;
      if (is_thr)
      begin
        next_r.rdata = {17'h0_0000, r.excess_threshold[idx]};
      end
      else if (is_dev)
      begin
        next_r.rdata = pwrite ? 32'h0000_0000 : r.deviation[idx];
        hit = !pwrite;
      end
      else
      begin
        case (paddr)
          prot_pkg::CTRL_OFS:
          begin
            next_r.rdata[prot_pkg::CTRL_SEL_ABORT_BIT] = r.sel_abort;
            next_r.rdata[prot_pkg::CTRL_LIM_INV_BIT] = r.lim_invert;
          end
          prot_pkg::OFF_FAULT_OFS:
          begin
            next_r.rdata[7:0] = r.disable_on_fault_set;
          end
          prot_pkg::CMD_OFS:
          begin
            next_r.rdata = 32'h0000_0000;
          end
          prot_pkg::STATUS_OFS:
          begin
            next_r.rdata[prot_pkg::STAT_AMP_LSB +: 8] = r.amp;
            next_r.rdata[prot_pkg::STAT_EXCESS_LSB +: 8] = r.excess;
            next_r.rdata[prot_pkg::STAT_OFF_LSB +: 8] = r.off_latch;
            next_r.rdata[prot_pkg::STAT_FAULT_BIT] = !r.fault_n;
            next_r.rdata[prot_pkg::STAT_ABORT_BIT] = !abort_n_s;
            hit = !pwrite;
          end
          prot_pkg::LIMITS_OFS:
          begin
            next_r.rdata[15:0] = {r.blk_rev, r.blk_fwd};
            hit = !pwrite;
          end
          default:
          begin
            hit = 1'b0;
          end
        endcase
      end
      // unmapped or read-only target: error, no data
      next_r.slverr = !hit;
      if (!hit)
      begin
        next_r.rdata = 32'h0000_0000;
      end
    end

    wr = psel && penable && r.ready && pwrite && !r.slverr;
    if (wr)
    begin
      if (is_thr)
      begin
        // zero is outside the legal range and is lifted to the minimum
        thr_w = (pwdata[14:0] == 15'h0000) ? prot_pkg::THRESH_MIN : pwdata[14:0];
        next_r.excess_threshold[idx] = thr_w;
      end
      else
      begin
        case (paddr)
          prot_pkg::CTRL_OFS:
          begin
            next_r.sel_abort = pwdata[prot_pkg::CTRL_SEL_ABORT_BIT];
            next_r.lim_invert = pwdata[prot_pkg::CTRL_LIM_INV_BIT];
          end
          prot_pkg::OFF_FAULT_OFS:
          begin
            next_r.disable_on_fault_set = pwdata[7:0];
          end
          prot_pkg::CMD_OFS:
          begin
            cmd_off = pwdata[prot_pkg::CMD_OFF_LSB +: 8];
            cmd_hold = pwdata[prot_pkg::CMD_HOLD_LSB +: 8];
            cmd_abort = pwdata[prot_pkg::CMD_ABORT_BIT];
            cmd_restart = pwdata[prot_pkg::CMD_RESTART_BIT];
          end
          default:
          begin
            cmd_off = 8'h00;
          end
        endcase
      end
    end

    // abort command waits for the next tick; a new command beats the clear
    if (tick || cmd_restart)
    begin
      next_r.abort_pend = 1'b0;
    end
    if (cmd_abort)
    begin
      next_r.abort_pend = 1'b1;
    end

    gen_abort = !abort_n_s || r.abort_pend;

    for (int i = 0; i < prot_pkg::NUM_AXES; i++)
    begin
      clr_off[i] = cmd_restart || cmd_hold[i];
      set_off[i] = cmd_off[i];
      if (tick)
      begin
        dev = cmd_pos[i] - enc_pos[i];
        mag = dev[31] ? (32'h0000_0000 - dev) : dev;
        exc = mag > {17'h0_0000, r.excess_threshold[i]};
        next_r.deviation[i] = dev;
        next_r.excess[i] = exc;
        if (exc && !r.excess[i])
        begin
          next_r.exc_evt = 1'b1;
        end
        ab = gen_abort
          || (r.sel_abort && !gin_s[prot_pkg::SEL_INPUT_MAP[i]]);
        next_r.halt[i] = ab;
        next_r.hold[i] = ab && !r.disable_on_fault_set[i];
        set_off[i] = set_off[i] || (r.disable_on_fault_set[i] && (ab || exc));
        // limits active low unless inverted
        fa = r.lim_invert ? fwd_n_s[i] : !fwd_n_s[i];
        ra = r.lim_invert ? rev_n_s[i] : !rev_n_s[i];
        next_r.blk_fwd[i] = fa;
        next_r.blk_rev[i] = ra;
        lh = (fa && moving_fwd[i]) || (ra && moving_rev[i]);
        next_r.decel[i] = lh;
        next_r.lim_hit[i] = lh;
        if (lh && !r.lim_hit[i])
        begin
          next_r.lim_evt = 1'b1;
        end
      end
      // shutdown request beats a simultaneous re-enable
      next_r.off_latch[i] = (r.off_latch[i] && !clr_off[i]) || set_off[i];
      next_r.amp[i] = !next_r.off_latch[i] && !next_r.excess[i]
        && !watchdog_fire && !self_reset;
    end

    next_r.fault_n = !((|next_r.excess) || self_reset);
    next_r.lamp = |next_r.excess;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.excess_threshold <= {prot_pkg::NUM_AXES{prot_pkg::THRESH_RESET}};
    end
    else
    begin
      r <= next_r;
    end
  end

  // high allows the amplifier, low disables it
  assign amp_drive_allow = r.amp;
  assign fault_n = r.fault_n;
  assign error_lamp = r.lamp;
  assign halt_now = r.halt;
  assign hold_here = r.hold;
  assign block_fwd = r.blk_fwd;
  assign block_rev = r.blk_rev;
  assign decel_stop = r.decel;
  assign limit_handler_routine = r.lim_evt;
  assign excess_deviation_routine = r.exc_evt;
  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;

endmodule

// file: dv/prot_checker.sv
// concurrent checks on the axis protection block ports
`timescale 1ns/100ps
module prot_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_fire,
  input wire logic self_reset,
  input wire logic abort_n,
  input wire logic [7:0] amp_drive_allow,
  input wire logic fault_n,
  input wire logic error_lamp,
  input wire logic [7:0] halt_now,
  input wire logic [7:0] hold_here,
  input wire logic [7:0] block_fwd,
  input wire logic [7:0] block_rev,
  input wire logic [7:0] decel_stop,
  input wire logic limit_handler_routine,
  input wire logic excess_deviation_routine
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wdog_amp_off_a: assert property (watchdog_fire |=> amp_drive_allow == 8'h00)
    else $error("amp enable still on after watchdog");
  self_fault_a: assert property (self_reset |=> !fault_n)
    else $error("fault output high during self reset");
  lamp_fault_a: assert property (error_lamp |-> !fault_n)
    else $error("fault output high with excess error");
  lamp_amp_a: assert property (error_lamp |-> amp_drive_allow != 8'hFF)
    else $error("all amps on with excess error");
  hold_sub_a: assert property (hold_here != 8'h00 |-> (hold_here & ~halt_now) == 8'h00)
    else $error("hold without halt");
  decel_block_a: assert property (decel_stop != 8'h00 |-> (decel_stop & ~(block_fwd | block_rev)) == 8'h00)
    else $error("decel without blocked direction");
  exc_event_a: assert property (excess_deviation_routine |-> error_lamp)
    else $error("excess event without excess");
  lim_event_a: assert property (limit_handler_routine |-> decel_stop != 8'h00)
    else $error("limit event without decel");
  abort_halt_a: assert property ($fell(abort_n) |-> ##[1:130] halt_now == 8'hFF)
    else $error("abort pin did not halt all axes");
  read_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("register access not answered in one cycle");
  refuse_pulse_a: assert property (pslverr |-> pready)
    else $error("error response outside access");
endmodule
bind motion_axis_protection prot_checker chk_u (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .watchdog_fire, .self_reset, .abort_n, .amp_drive_allow, .fault_n, .error_lamp,
  .halt_now, .hold_here, .block_fwd, .block_rev, .decel_stop, .limit_handler_routine,
  .excess_deviation_routine);

// file: dv/axis_far_end.sv
// far side model: abort, selective abort and limit switch pins
`timescale 1ns/100ps
module axis_far_end (
  input wire logic pclk,
  input wire logic abort_on,
  input wire logic [7:0] sel_on,
  input wire logic [7:0] fwd_hit,
  input wire logic [7:0] rev_hit,
  input wire logic lim_inv,
  output logic abort_n,
  output logic [16:1] general_in,
  output logic [7:0] fwd_limit_n,
  output logic [7:0] rev_limit_n
);
  initial
  begin
    abort_n = 1'b1;
    general_in = '1;
    fwd_limit_n = '1;
    rev_limit_n = '1;
  end
  // pins move just after the edge, the design synchronises them anyway
  always @(posedge pclk)
  begin
    abort_n <= ~abort_on;
    for (int i = 0; i < 8; i++)
      general_in[prot_pkg::SEL_INPUT_MAP[i]] <= ~sel_on[i];
    fwd_limit_n <= ~(fwd_hit ^ {8{lim_inv}});
    rev_limit_n <= ~(rev_hit ^ {8{lim_inv}});
  end
endmodule

// file: dv/motion_axis_protection_tb.sv
// self-checking bench for the axis protection block
`timescale 1ns/100ps
module motion_axis_protection_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, fault_n, error_lamp, limit_handler_routine;
  logic excess_deviation_routine, seen_lim, seen_exc, abort_n, ex;
  logic [7:0][31:0] cmd_pos = '0, enc_pos = '0;
  logic [7:0] moving_fwd = '0, moving_rev = '0, amp_drive_allow, halt_now, hold_here;
  logic [7:0] block_fwd, block_rev, decel_stop, fwd_limit_n, rev_limit_n;
  logic [7:0] sel_on = '0, fwd_hit = '0, rev_hit = '0;
  logic [16:1] general_in;
  logic watchdog_fire = 1'b0, self_reset = 1'b0, abort_on = 1'b0, lim_inv = 1'b0;
  int n_errors = 0, total_checks = 0, cycles = 0, seed = 32'hDAABE670, dv, th, ax;
  localparam logic [11:0] CMD = prot_pkg::CMD_OFS;
  always #4 pclk = ~pclk;
  motion_axis_protection dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cmd_pos, .enc_pos, .moving_fwd, .moving_rev, .watchdog_fire,
    .self_reset, .abort_n, .general_in, .fwd_limit_n, .rev_limit_n, .amp_drive_allow,
    .fault_n, .error_lamp, .halt_now, .hold_here, .block_fwd, .block_rev, .decel_stop,
    .limit_handler_routine, .excess_deviation_routine);
  axis_far_end far_u (.pclk, .abort_on, .sel_on, .fwd_hit, .rev_hit, .lim_inv, .abort_n,
    .general_in, .fwd_limit_n, .rev_limit_n);
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_errors++;
      test_done();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // no wait-state count assumed; only the cycle ceiling ends a hung access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // two ticks plus sync: pin changes and events are settled and caught
  task tick();
    seen_lim = 1'b0;
    seen_exc = 1'b0;
    repeat (260)
    begin
      @(posedge pclk);
      seen_lim |= limit_handler_routine;
      seen_exc |= excess_deviation_routine;
    end
  endtask
  function logic [11:0] tha(int i);
    return prot_pkg::THRESH_BASE + 12'(4 * i);
  endfunction
  function logic exc(int d, int t);
    return (d < 0 ? -d : d) > t;
  endfunction
  initial
  begin
    repeat (8) @(posedge pclk);
    chk(32'({fault_n, amp_drive_allow}), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, tha(i), '0);
      chk(rd, 32'h4000);
    end
    apb(1'b1, tha(0), 32'h0);
    apb(1'b0, tha(0), '0);
    chk(rd, 32'h1);
    apb(1'b1, tha(0), 32'h7FFF);
    apb(1'b0, tha(0), '0);
    chk(rd, 32'h7FFF);
    apb(1'b0, 12'h0FC, '0);
    chk(32'(er), 32'h1);
    apb(1'b1, prot_pkg::DEV_BASE, 32'h5);
    chk(32'(er), 32'h1);
    $display("test registers finished");
    for (int k = 0; k < 8; k++)
    begin
      ax = $unsigned($random(seed)) % 8;
      th = 1 + $unsigned($random(seed)) % 300;
      dv = (k == 0) ? th : (k == 1) ? -(th + 1) : $random(seed) % 600;
      ex = exc(dv, th);
      apb(1'b1, tha(ax), 32'(th));
      cmd_pos[ax] <= 32'(dv + 1000);
      enc_pos[ax] <= 32'h3E8;
      tick();
      apb(1'b0, prot_pkg::DEV_BASE + 12'(4 * ax), '0);
      chk(rd, 32'(dv));
      chk(32'({fault_n, error_lamp, seen_exc}), 32'({!ex, ex, ex}));
      chk(32'(amp_drive_allow), 32'(ex ? 8'(~(8'h01 << ax)) : 8'hFF));
      cmd_pos[ax] <= '0;
      enc_pos[ax] <= '0;
      tick();
    end
    $display("test excess finished");
    apb(1'b1, prot_pkg::OFF_FAULT_OFS, 32'h04);
    cmd_pos[2] <= 32'h8000;
    tick();
    cmd_pos[2] <= '0;
    tick();
    chk(32'(amp_drive_allow), 32'hFB);
    apb(1'b1, CMD, 32'h400);
    tick();
    chk(32'(amp_drive_allow), 32'hFF);
    apb(1'b1, CMD, 32'h01);
    chk(32'(amp_drive_allow), 32'hFE);
    apb(1'b0, prot_pkg::STATUS_OFS, '0);
    chk(rd, 32'h0001_00FE);
    apb(1'b1, CMD, 32'h20000);
    tick();
    chk(32'(amp_drive_allow), 32'hFF);
    $display("test off latch finished");
    apb(1'b1, prot_pkg::OFF_FAULT_OFS, 32'h0F);
    abort_on <= 1'b1;
    tick();
    chk(32'({halt_now, hold_here, amp_drive_allow}), 32'hFFF0F0);
    abort_on <= 1'b0;
    tick();
    apb(1'b1, CMD, 32'h20000);
    chk(32'(amp_drive_allow), 32'hFF);
    apb(1'b1, CMD, 32'h10000);
    tick();
    chk(32'(amp_drive_allow), 32'hF0);
    apb(1'b1, CMD, 32'h20000);
    apb(1'b1, prot_pkg::CTRL_OFS, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      sel_on <= 8'h01 << i;
      tick();
      chk(32'(halt_now), 32'(8'h01 << i));
      sel_on <= '0;
      tick();
    end
    apb(1'b1, CMD, 32'h20000);
    tick();
    chk(32'(amp_drive_allow), 32'hFF);
    $display("test abort finished");
    moving_fwd <= 8'h01;
    moving_rev <= 8'h02;
    for (int p = 0; p < 2; p++)
    begin
      lim_inv <= p[0];
      apb(1'b1, prot_pkg::CTRL_OFS, 32'(p * 2));
      tick();
      fwd_hit <= 8'h03;
      rev_hit <= 8'h02;
      tick();
      chk(32'({block_fwd, block_rev, decel_stop}), 32'h030203);
      chk(32'(seen_lim), 32'h1);
      apb(1'b0, prot_pkg::LIMITS_OFS, '0);
      chk(rd, 32'h0203);
      fwd_hit <= '0;
      rev_hit <= '0;
    end
    $display("test limits finished");
    watchdog_fire <= 1'b1;
    self_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'({fault_n, amp_drive_allow}), 32'h0);
    watchdog_fire <= 1'b0;
    self_reset <= 1'b0;
    tick();
    chk(32'({fault_n, amp_drive_allow}), 32'h1FF);
    $display("test watchdog finished");
    test_done();
  end
endmodule
